// ### rtl/isc_pkg.sv
// Constants shared by the interrupt status collector
package isc_pkg;
	localparam int ISC_AW = 8;
	localparam int ISC_DW = 32;
	// Register byte addresses
	localparam logic [7:0] ISC_ADDR_OUT_CTRL = 8'h54;
	localparam logic [7:0] ISC_ADDR_STATUS = 8'h58;
	localparam logic [7:0] ISC_ADDR_ENABLE = 8'h5c;
	// Status bit positions
	localparam int ISC_BIT_SOFTWARE = 31;
	localparam int ISC_BIT_READY = 30;
	localparam int ISC_BIT_TIMESTAMP = 29;
	localparam int ISC_BIT_FABRIC = 28;
	localparam int ISC_BIT_PORT2 = 27;
	localparam int ISC_BIT_PORT1 = 26;
	localparam int ISC_BIT_TX_HALT = 25;
	localparam int ISC_BIT_RX_HALT = 24;
	localparam int ISC_BIT_DROP_MID = 23;
	localparam int ISC_BIT_BUF_LOADED = 21;
	localparam int ISC_BIT_RX_XFER = 20;
	localparam int ISC_BIT_TIMER_WRAP = 19;
	localparam int ISC_BIT_POWER = 17;
	localparam int ISC_BIT_TX_STS_OVF = 16;
	localparam int ISC_BIT_OVERSIZE = 15;
	// Write-one-to-clear bits, summaries and reserved bits
	localparam logic [31:0] ISC_W1C_MASK = 32'hc3bb8000;
	localparam logic [31:0] ISC_RO_MASK = 32'h3c000000;
	localparam logic [31:0] ISC_IMPL_MASK = 32'hffbb8000;
	localparam logic [31:0] ISC_STATUS_RESET = 32'h00000000;
	localparam logic [31:0] ISC_ENABLE_RESET = 32'h00000000;
	// Output control register fields
	localparam int ISC_BIT_OUT_EN = 8;
	localparam int ISC_BIT_MASTER = 12;
	localparam logic [31:0] ISC_OUT_CTRL_WMASK = 32'h00000100;
	// Counter and timer values
	localparam int ISC_TIMER_W = 16;
	localparam logic [15:0] ISC_TIMER_ZERO = 16'h0000;
	localparam logic [15:0] ISC_TIMER_MAX = 16'hffff;
	localparam logic [31:0] ISC_RDATA_IDLE = 32'h00000000;
endpackage : isc_pkg

// ### rtl/isc_collector.sv
// Top-level interrupt status collector with register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
//
// Behaviour
// [R1] Each flag latches its event regardless of its enable bit.
// [R2] Writing one to a write-one-to-clear flag clears it.
// [R3] Bit 31 sets when software enable bit is set; cleared by one-write.
// [R4] Bit 30 sets once device is ready after reset; cleared by one-write.
// [R5] Bit 29 mirrors the time-stamp unit pending event, read-only.
// [R6] Bit 28 mirrors pending switch fabric events, read-only.
// [R7] Bits 27 and 26 mirror port 2 and port 1 transceiver events.
// [R8] Bit 25 sets when stop-transmit is set and transmitter halted.
// [R9] Bit 24 sets when the receiver reaches its halted state.
// [R10] Bit 23 sets when the drop counter crosses into top bit set.
// [R11] Bit 21 sets when a notify-marked buffer is fully loaded.
// [R12] Bit 20 sets when the programmed receive transfer count completes.
// [R13] Bit 19 sets when timer count wraps from zero to maximum.
// [R14] Bit 17 sets on power event, independent of wake output enable.
// [R15] Bit 17 clears on one-write only after control bits cleared.
// [R16] Power flag reaches the request pin without quiet-interval delay.
// [R17] Bit 16 sets when the transmit status FIFO overflows.
// [R18] Bit 15 sets when an oversize packet is received.
// [R19] Master indication is set when any enabled flag is active.
// [R20] Output enable clear holds the request pin de-asserted.
// [R21] Zero writes, summary and reserved bits are unchanged; reserved read 0.
// [R22] A set in the same cycle as a clear wins.
module isc_collector
	import isc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [ISC_AW-1:0] i_addr,
	input wire logic [ISC_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_timestamp_unit_event,
	input wire logic i_fabric_event,
	input wire logic i_second_port_transceiver_event,
	input wire logic i_first_port_transceiver_event,
	input wire logic i_stop_transmit,
	input wire logic i_transmitter_halted,
	input wire logic i_receiver_halted,
	input wire logic i_drop_counter_msb,
	input wire logic i_buffer_loaded,
	input wire logic i_completion_notify_mark,
	input wire logic i_rx_transfer_done,
	input wire logic [ISC_TIMER_W-1:0] i_general_timer_count,
	input wire logic i_power_event,
	input wire logic i_power_mgmt_pending,
	input wire logic i_tx_status_overflow,
	input wire logic i_rx_oversize,
	output logic [ISC_DW-1:0] o_rdata,
	output logic o_master_irq,
	output logic o_irq
);

	logic [31:0] interrupt_status;
	logic [31:0] interrupt_enable;
	logic out_enable;
	logic ready_pending;
	logic tx_halted_seen;
	logic rx_halted_seen;
	logic drop_msb_seen;
	logic [ISC_TIMER_W-1:0] timer_seen;
	logic timer_valid;
	logic [31:0] event_set;
	logic [31:0] host_clear;
	logic [31:0] summary;
	logic [31:0] next_status;
	logic next_master;
	logic wr_status;
	logic wr_enable;
	logic wr_out_ctrl;

	assign wr_status = i_wr && (i_addr == ISC_ADDR_STATUS);
	assign wr_enable = i_wr && (i_addr == ISC_ADDR_ENABLE);
	assign wr_out_ctrl = i_wr && (i_addr == ISC_ADDR_OUT_CTRL);

	// History of source levels for edge detection
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_halted_seen <= 1'b0;
			rx_halted_seen <= 1'b0;
			drop_msb_seen <= 1'b0;
			timer_seen <= ISC_TIMER_ZERO;
			timer_valid <= 1'b0;
		end else begin
			tx_halted_seen <= i_transmitter_halted && i_stop_transmit;
			rx_halted_seen <= i_receiver_halted;
			drop_msb_seen <= i_drop_counter_msb;
			timer_seen <= i_general_timer_count;
			timer_valid <= 1'b1;
		end
	end

	// Ready flag is raised once, on the first cycle after reset release
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ready_pending <= 1'b1;
		end else begin
			ready_pending <= 1'b0; // R4
		end
	end

	// Enable register; software flag raised by a rising enable bit
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			interrupt_enable <= ISC_ENABLE_RESET;
		end else if (wr_enable) begin
			interrupt_enable <= i_wdata & ISC_IMPL_MASK;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_enable <= 1'b0;
		end else if (wr_out_ctrl) begin
			out_enable <= i_wdata[ISC_BIT_OUT_EN];
		end
	end

	// Event detection; only the software flag reads its enable bit here
	always_comb begin
		event_set = '0; // R1
		event_set[ISC_BIT_SOFTWARE] = wr_enable
			&& i_wdata[ISC_BIT_SOFTWARE]
			&& !interrupt_enable[ISC_BIT_SOFTWARE]; // R3
		event_set[ISC_BIT_READY] = ready_pending; // R4
		event_set[ISC_BIT_TX_HALT] = i_stop_transmit
			&& i_transmitter_halted && !tx_halted_seen; // R8
		event_set[ISC_BIT_RX_HALT] = i_receiver_halted
			&& !rx_halted_seen; // R9
		event_set[ISC_BIT_DROP_MID] = i_drop_counter_msb
			&& !drop_msb_seen; // R10
		event_set[ISC_BIT_BUF_LOADED] = i_buffer_loaded
			&& i_completion_notify_mark; // R11
		event_set[ISC_BIT_RX_XFER] = i_rx_transfer_done; // R12
		event_set[ISC_BIT_TIMER_WRAP] = timer_valid
			&& (timer_seen == ISC_TIMER_ZERO)
			&& (i_general_timer_count == ISC_TIMER_MAX); // R13
		event_set[ISC_BIT_POWER] = i_power_event; // R14
		event_set[ISC_BIT_TX_STS_OVF] = i_tx_status_overflow; // R17
		event_set[ISC_BIT_OVERSIZE] = i_rx_oversize; // R18
	end

	// Summary bits follow their sources, so never stored as flags
	always_comb begin
		summary = '0;
		summary[ISC_BIT_TIMESTAMP] = i_timestamp_unit_event; // R5
		summary[ISC_BIT_FABRIC] = i_fabric_event; // R6
		summary[ISC_BIT_PORT2] = i_second_port_transceiver_event; // R7
		summary[ISC_BIT_PORT1] = i_first_port_transceiver_event; // R7
	end

	// Host clears; the power flag resists while control bits pend
	always_comb begin
		host_clear = '0;
		if (wr_status) begin
			host_clear = i_wdata & ISC_W1C_MASK; // R2 R21
		end
		if (i_power_mgmt_pending) begin
			host_clear[ISC_BIT_POWER] = 1'b0; // R15
		end
	end

	// Status bits: summaries follow sources, sticky flags with set winning over clear, reserved zero
	genvar gi;
	generate
		for (gi = 0; gi < ISC_DW; gi++) begin : g_flag
			if (ISC_RO_MASK[gi]) begin : g_sum
				always_ff @(posedge i_clk or negedge i_resetn) begin
					if (!i_resetn) begin
						interrupt_status[gi] <= ISC_STATUS_RESET[gi];
					end else begin
						interrupt_status[gi] <= summary[gi]; // R5 R6 R7
					end
				end
			end else if (ISC_W1C_MASK[gi]) begin : g_w1c
				always_ff @(posedge i_clk or negedge i_resetn) begin
					if (!i_resetn) begin
						interrupt_status[gi] <= ISC_STATUS_RESET[gi];
					end else begin
						interrupt_status[gi] <= event_set[gi]
							|| (interrupt_status[gi] && !host_clear[gi]); // R22
					end
				end
			end else begin : g_rsv
				assign interrupt_status[gi] = 1'b0; // R21
			end
		end
	endgenerate

	// Next-cycle view so the master and pin outputs track the flags
	always_comb begin
		next_status = ((interrupt_status & ~host_clear) | event_set)
			& ISC_W1C_MASK;
		next_status = next_status | summary;
		next_master = |(next_status & interrupt_enable);
	end

	// No quiet interval exists here, so the power flag is never delayed
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_master_irq <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			o_master_irq <= next_master; // R19
			o_irq <= next_master && out_enable; // R16 R20
		end
	end

	// Read port; unmapped addresses read zero
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= ISC_RDATA_IDLE;
		end else if (i_rd) begin
			case (i_addr)
				ISC_ADDR_STATUS: o_rdata <= interrupt_status;
				ISC_ADDR_ENABLE: o_rdata <= interrupt_enable;
				ISC_ADDR_OUT_CTRL: begin
					o_rdata <= ISC_RDATA_IDLE;
					o_rdata[ISC_BIT_OUT_EN] <= out_enable;
					o_rdata[ISC_BIT_MASTER] <= o_master_irq;
				end
				default: o_rdata <= ISC_RDATA_IDLE;
			endcase
		end else begin
			o_rdata <= ISC_RDATA_IDLE;
		end
	end

	property p_latch_unmasked;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_rx_oversize && !interrupt_enable[ISC_BIT_OVERSIZE])
			|=> interrupt_status[ISC_BIT_OVERSIZE];
	endproperty
	a_latch_unmasked: assert property (p_latch_unmasked) // R1
		else $error("oversize flag not latched while masked");

	property p_w1c_clear;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_status && i_wdata[ISC_BIT_RX_HALT]
			&& !event_set[ISC_BIT_RX_HALT])
			|=> !interrupt_status[ISC_BIT_RX_HALT];
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) // R2
		else $error("receiver halted flag survived a one-write");

	property p_sw_set;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_enable && i_wdata[ISC_BIT_SOFTWARE]
			&& !interrupt_enable[ISC_BIT_SOFTWARE])
			|=> interrupt_status[ISC_BIT_SOFTWARE];
	endproperty
	a_sw_set: assert property (p_sw_set) // R3
		else $error("software flag not raised by enable");

	property p_ready_once;
		@(posedge i_clk) disable iff (!i_resetn)
		$fell(ready_pending) |-> interrupt_status[ISC_BIT_READY];
	endproperty
	a_ready_once: assert property (p_ready_once) // R4
		else $error("ready flag missing after reset");

	property p_summary;
		@(posedge i_clk) disable iff (!i_resetn)
		##1 (interrupt_status[ISC_BIT_FABRIC]
			== $past(i_fabric_event))
		&& (interrupt_status[ISC_BIT_PORT2]
			== $past(i_second_port_transceiver_event));
	endproperty
	a_summary: assert property (p_summary) // R6 R7
		else $error("summary bit does not follow source");

	property p_timer_wrap;
		@(posedge i_clk) disable iff (!i_resetn)
		(timer_valid && timer_seen == ISC_TIMER_ZERO
			&& i_general_timer_count == ISC_TIMER_MAX)
			|=> interrupt_status[ISC_BIT_TIMER_WRAP];
	endproperty
	a_timer_wrap: assert property (p_timer_wrap) // R13
		else $error("timer wrap not flagged");

	property p_power_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		(interrupt_status[ISC_BIT_POWER] && i_power_mgmt_pending)
			|=> interrupt_status[ISC_BIT_POWER];
	endproperty
	a_power_hold: assert property (p_power_hold) // R15
		else $error("power flag cleared while control bits pend");

	property p_master;
		@(posedge i_clk) disable iff (!i_resetn)
		##1 o_master_irq == |(interrupt_status
			& $past(interrupt_enable));
	endproperty
	a_master: assert property (p_master) // R19
		else $error("master indication wrong");

	property p_pin_off;
		@(posedge i_clk) disable iff (!i_resetn)
		(!out_enable) |=> !o_irq;
	endproperty
	a_pin_off: assert property (p_pin_off) // R20
		else $error("request pin asserted while disabled");

	property p_reserved;
		@(posedge i_clk) disable iff (!i_resetn)
		(interrupt_status & ~ISC_IMPL_MASK) == '0;
	endproperty
	a_reserved: assert property (p_reserved) // R21
		else $error("reserved status bit nonzero");

	property p_set_wins;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_status && i_wdata[ISC_BIT_TX_STS_OVF]
			&& i_tx_status_overflow)
			|=> interrupt_status[ISC_BIT_TX_STS_OVF];
	endproperty
	a_set_wins: assert property (p_set_wins) // R22
		else $error("overflow event lost against clear");

	property p_tx_halt;
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_stop_transmit && i_transmitter_halted)
			|=> interrupt_status[ISC_BIT_TX_HALT];
	endproperty
	a_tx_halt: assert property (p_tx_halt) // R8
		else $error("transmitter halt not flagged");

	property p_rx_halt;
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_receiver_halted)
			|=> interrupt_status[ISC_BIT_RX_HALT];
	endproperty
	a_rx_halt: assert property (p_rx_halt) // R9
		else $error("receiver halt not flagged");

	property p_drop_mid;
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_drop_counter_msb)
			|=> interrupt_status[ISC_BIT_DROP_MID];
	endproperty
	a_drop_mid: assert property (p_drop_mid) // R10
		else $error("drop counter midpoint not flagged");

	property p_buf_loaded;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_buffer_loaded && i_completion_notify_mark)
			|=> interrupt_status[ISC_BIT_BUF_LOADED];
	endproperty
	a_buf_loaded: assert property (p_buf_loaded) // R11
		else $error("loaded buffer notice not flagged");

	property p_rx_xfer;
		@(posedge i_clk) disable iff (!i_resetn)
		i_rx_transfer_done
			|=> interrupt_status[ISC_BIT_RX_XFER];
	endproperty
	a_rx_xfer: assert property (p_rx_xfer) // R12
		else $error("receive transfer completion not flagged");

	property p_power_set;
		@(posedge i_clk) disable iff (!i_resetn)
		i_power_event
			|=> interrupt_status[ISC_BIT_POWER];
	endproperty
	a_power_set: assert property (p_power_set) // R14
		else $error("power event not flagged");

	property p_power_pin;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_power_event && interrupt_enable[ISC_BIT_POWER]
			&& out_enable) |=> o_irq;
	endproperty
	a_power_pin: assert property (p_power_pin) // R16
		else $error("power event delayed on request pin");

	property p_zero_write;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_status && !i_wdata[ISC_BIT_OVERSIZE]
			&& interrupt_status[ISC_BIT_OVERSIZE])
			|=> interrupt_status[ISC_BIT_OVERSIZE];
	endproperty
	a_zero_write: assert property (p_zero_write) // R21
		else $error("zero write cleared a flag");

endmodule : isc_collector

// ### sim/isc_host.sv
// Host-side register access model for the interrupt status collector
`timescale 1ns/1ns
module isc_host
	import isc_pkg::*;
(
	input wire logic i_clk,
	input wire logic [ISC_DW-1:0] i_rdata,
	output logic [ISC_AW-1:0] o_addr,
	output logic [ISC_DW-1:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 32'h00000000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// One-cycle write; data inverted once released so stale values never match
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
		o_addr <= ~a;
	endtask : wr

	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : rd
endmodule : isc_host

// ### sim/isc_collector_tb.sv
// Self-checking bench for the interrupt status collector
`timescale 1ns/1ns
module isc_collector_tb;
	import isc_pkg::*;
	logic clk, resetn, wr, rd, ts, fab, p2, p1, stop, halt, rxh, msb, bl, mark;
	logic xfer, pwr, pend, ovf, ovs, master, irq;
	logic [15:0] tmr;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	int errors, checks_done, cycles;
	int bits[9] = '{15, 16, 17, 19, 20, 21, 23, 24, 25};

	isc_host isc_host_i (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	isc_collector isc_collector_i (.i_clk(clk), .i_resetn(resetn),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.i_timestamp_unit_event(ts), .i_fabric_event(fab),
		.i_second_port_transceiver_event(p2),
		.i_first_port_transceiver_event(p1), .i_stop_transmit(stop),
		.i_transmitter_halted(halt), .i_receiver_halted(rxh),
		.i_drop_counter_msb(msb), .i_buffer_loaded(bl),
		.i_completion_notify_mark(mark), .i_rx_transfer_done(xfer),
		.i_general_timer_count(tmr), .i_power_event(pwr),
		.i_power_mgmt_pending(pend), .i_tx_status_overflow(ovf),
		.i_rx_oversize(ovs), .o_rdata(rdata), .o_master_irq(master),
		.o_irq(irq));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			$display("mismatch at %0t: run timed out", $time);
			conclude();
		end
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: pin %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic rs(input logic [31:0] exp);
		isc_host_i.rd(ISC_ADDR_STATUS, d);
		chk32(d, exp);
	endtask : rs

	task automatic drive(input int b, input logic v);
		case (b)
			15: ovs <= v;
			16: ovf <= v;
			17: pwr <= v;
			19: tmr <= v ? 16'hffff : 16'h0000;
			20: xfer <= v;
			21: begin
				bl <= v;
				mark <= v;
			end
			23: msb <= v;
			24: rxh <= v;
			25: begin
				stop <= v;
				halt <= v;
			end
			26: p1 <= v;
			27: p2 <= v;
			28: fab <= v;
			29: ts <= v;
			default: ;
		endcase
	endtask : drive

	task automatic fire(input int b);
		@(posedge clk);
		drive(b, 1'b1);
		@(posedge clk);
		drive(b, 1'b0);
	endtask : fire

	initial begin
		{resetn, ts, fab, p2, p1, stop, halt, rxh, msb, bl, mark} = '0;
		{xfer, pwr, pend, ovf, ovs} = '0;
		tmr = 16'h0000;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rs(32'h40000000);
		isc_host_i.rd(8'h00, d);
		chk32(d, 32'h00000000);
		isc_host_i.wr(ISC_ADDR_STATUS, 32'h40000000);
		rs(32'h00000000);
		foreach (bits[i]) begin
			fire(bits[i]);
			rs(32'h1 << bits[i]);
			chk1(master, 1'b0);
			isc_host_i.wr(ISC_ADDR_STATUS, 32'h00000000);
			rs(32'h1 << bits[i]);
			isc_host_i.wr(ISC_ADDR_STATUS, 32'h1 << bits[i]);
			rs(32'h00000000);
		end
		for (int b = 26; b < 30; b++) begin
			@(posedge clk);
			drive(b, 1'b1);
			isc_host_i.wr(ISC_ADDR_STATUS, 32'h3c440000);
			rs(32'h1 << b);
			@(posedge clk);
			drive(b, 1'b0);
			rs(32'h00000000);
		end
		// Halt without stop and mark without load must not flag
		@(posedge clk);
		halt <= 1'b1;
		mark <= 1'b1;
		@(posedge clk);
		{halt, mark} <= 2'b00;
		rs(32'h00000000);
		@(posedge clk);
		pend <= 1'b1;
		fire(17);
		isc_host_i.wr(ISC_ADDR_STATUS, 32'h00020000);
		rs(32'h00020000);
		@(posedge clk);
		pend <= 1'b0;
		isc_host_i.wr(ISC_ADDR_STATUS, 32'h00020000);
		rs(32'h00000000);
		// Event landing on the clearing edge must survive
		fork
			isc_host_i.wr(ISC_ADDR_STATUS, 32'h00008000);
			fire(15);
		join
		rs(32'h00008000);
		isc_host_i.wr(ISC_ADDR_STATUS, 32'h00008000);
		isc_host_i.wr(ISC_ADDR_ENABLE, 32'h80020000);
		rs(32'h80000000);
		chk1(master, 1'b1);
		chk1(irq, 1'b0);
		isc_host_i.rd(ISC_ADDR_ENABLE, d);
		chk32(d, 32'h80020000);
		isc_host_i.rd(ISC_ADDR_OUT_CTRL, d);
		chk32(d, 32'h00001000);
		isc_host_i.wr(ISC_ADDR_OUT_CTRL, 32'h00000100);
		isc_host_i.rd(ISC_ADDR_OUT_CTRL, d);
		chk32(d, 32'h00001100);
		rs(32'h80000000);
		chk1(irq, 1'b1);
		isc_host_i.wr(ISC_ADDR_STATUS, 32'h80000000);
		rs(32'h00000000);
		chk1(master, 1'b0);
		chk1(irq, 1'b0);
		fire(17);
		#1;
		chk1(irq, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rs(32'h40000000);
		chk1(irq, 1'b0);
		conclude();
	end
endmodule : isc_collector_tb
